// *** tchq_core.sv ***
// Top of the touch controller host-port command interpreter.
// Assumes an outside byte engine decodes host accesses into requests.
`timescale 1ns/10ps
module tchq_core
  import tchq_pkg::*;
#(
  parameter int unsigned BOOT_CYC = BOOT_CYC_DEF,
  parameter int unsigned FLASH_CYC = FLASH_CYC_DEF
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_vld,
  input wire logic [1:0] req_cmd,
  input wire logic bus_activity,
  input wire logic [1:0] sleep_sel,
  input wire logic avg_en,
  input wire logic [1:0] avg_depth,
  input wire logic drop_en,
  input wire logic scan_start,
  input wire logic scan_done,
  input wire logic [RAW_W-1:0] scan_raw,
  output logic boot_done,
  output logic req_ack,
  output logic busy,
  output logic store_fail,
  output logic store_ok,
  output logic smp_drop,
  output logic smp_vld,
  output logic [RAW_W-1:0] smp_out,
  output logic touch,
  output logic [RAW_W-1:0] baseline
);
  tchq_state_t state_q;
  logic [31:0] cnt_q;
  logic [1:0] cmd_q;
  logic dirty_q;
  logic accept;
  logic f_vld;
  logic [RAW_W-1:0] f_val;
  logic [RAW_W-1:0] pick;
  logic first_q;
  logic frozen_q;
  logic [RAW_W:0] thresh;

  // Store may not run at the two fast sleep rates.
  function automatic logic store_blocked(input logic [1:0] s);
    return (s == SLEEP_512HZ) || (s == SLEEP_64HZ);
  endfunction : store_blocked

  // Requests are answered after a short fixed service delay of a few
  // cycles, far inside both acknowledge limits.
  localparam logic [31:0] SERVE_CYC = 32'h0000_0004;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q <= ST_BOOT;
      cnt_q <= 32'h0000_0000;
      cmd_q <= CMD_CRIT;
      req_ack <= 1'b0;
      store_fail <= 1'b0;
      store_ok <= 1'b0;
    end
    else
    begin
      req_ack <= 1'b0;
      store_fail <= 1'b0;
      store_ok <= 1'b0;
      unique case (state_q)
        ST_BOOT:
        begin
          // Requests during boot are ignored; the host must wait.
          if (cnt_q >= BOOT_CYC - 1)
          begin
            state_q <= ST_IDLE;
            cnt_q <= 32'h0000_0000;
          end
          else
            cnt_q <= cnt_q + 32'h1;
        end
        ST_IDLE:
        begin
          if (req_vld && !busy)
          begin
            cmd_q <= req_cmd;
            cnt_q <= 32'h0000_0000;
            state_q <= ST_SERVE;
          end
        end
        ST_SERVE:
        begin
          if (cnt_q >= SERVE_CYC - 1)
          begin
            req_ack <= 1'b1;
            cnt_q <= 32'h0000_0000;
            if (cmd_q == CMD_STORE && store_blocked(sleep_sel))
              state_q <= ST_FAIL;
            else if (cmd_q == CMD_STORE)
              state_q <= ST_FLASH;
            else
              state_q <= ST_IDLE;
          end
          else
            cnt_q <= cnt_q + 32'h1;
        end
        ST_FLASH:
        begin
          // All requests wait here until the store completes.
          if (cnt_q >= FLASH_CYC - 1)
          begin
            store_ok <= 1'b1;
            state_q <= ST_IDLE;
          end
          else
            cnt_q <= cnt_q + 32'h1;
        end
        ST_FAIL:
        begin
          store_fail <= 1'b1;
          state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  assign boot_done = (state_q != ST_BOOT);
  // Busy covers the acknowledge cycle, so a request still held by the
  // host at that edge is not taken a second time.
  assign busy = (state_q != ST_IDLE) || req_ack;

  // Bus traffic seen anywhere in a scan taints its sample.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      dirty_q <= 1'b0;
    else if (scan_start)
      dirty_q <= bus_activity;
    else if (bus_activity)
      dirty_q <= 1'b1;
  end

  assign accept = scan_done && !(drop_en && (dirty_q || bus_activity));

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      smp_drop <= 1'b0;
    else
      smp_drop <= scan_done && !accept;
  end

  tchq_avg u_avg
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .depth_sel(avg_depth),
    .smp_vld(accept),
    .smp_raw(scan_raw),
    .avg_vld(f_vld),
    .avg_out(f_val)
  );

  // Raw and averaged values both settle the cycle after a sample is taken.
  logic [RAW_W-1:0] raw_q;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      raw_q <= 16'h0000;
    else if (accept)
      raw_q <= scan_raw;
  end

  assign pick = avg_en ? f_val : raw_q;

  // One extra bit keeps the threshold from wrapping near full scale.
  assign thresh = {1'b0, baseline} + {1'b0, TOUCH_DELTA};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      smp_vld <= 1'b0;
      smp_out <= 16'h0000;
    end
    else
    begin
      smp_vld <= f_vld;
      if (f_vld)
        smp_out <= pick;
    end
  end

  // The first sample after reset seeds the baseline. With averaging on,
  // a finger present then is reported and the baseline freezes; this
  // quirk is kept on purpose so the system matches the shipped part.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      first_q <= 1'b1;
      frozen_q <= 1'b0;
      baseline <= 16'h0000;
      touch <= 1'b0;
    end
    else if (f_vld)
    begin
      first_q <= 1'b0;
      if (first_q)
      begin
        baseline <= pick;
        if (avg_en && pick > TOUCH_DELTA)
        begin
          frozen_q <= 1'b1;
          touch <= 1'b1;
        end
      end
      else if (!frozen_q)
      begin
        touch <= {1'b0, pick} > thresh;
        if (!({1'b0, pick} > thresh))
          baseline <= pick;
      end
    end
  end
endmodule : tchq_core

// *** tchq_pkg.sv ***
// Constants shared by the touch host-port command interpreter.
// Assumes a single 200 MHz clock and a host-side byte engine outside.
// Overview of operation
// - Accesses to critical registers are acknowledged within 140 us.
// - A store-to-flash command is acknowledged within 100 us, then all else waits until the store ends.
// - An averaging filter smooths raw counts over 2, 4, 8 or 16 samples.
// - With the drop filter on, a sample whose scan saw bus traffic is discarded.
// - Store-to-flash fails while the sleep interval is 512 Hz or 64 Hz.
// - With averaging on, a touch at power-up is reported and freezes the baseline.
package tchq_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CRIT_ACK_US = 140;
  localparam int unsigned STORE_ACK_US = 100;
  localparam int unsigned CRIT_ACK_CYC = CRIT_ACK_US * CLK_MHZ;
  localparam int unsigned STORE_ACK_CYC = STORE_ACK_US * CLK_MHZ;
  localparam int unsigned BOOT_CYC_DEF = 1000;
  localparam int unsigned FLASH_CYC_DEF = 20000;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned SLP_512HZ = 0;
  localparam int unsigned SLP_64HZ = 1;
  localparam int unsigned SLP_8HZ = 2;
  localparam int unsigned SLP_1HZ = 3;
  localparam logic [1:0] SLEEP_512HZ = 2'h0;
  localparam logic [1:0] SLEEP_64HZ = 2'h1;
  localparam logic [1:0] SLEEP_8HZ = 2'h2;
  localparam logic [1:0] SLEEP_1HZ = 2'h3;
  localparam logic [1:0] CMD_CRIT = 2'h0;
  localparam logic [1:0] CMD_STORE = 2'h1;
  localparam logic [1:0] CMD_OTHER = 2'h2;
  localparam int unsigned ACC_W = 20;
  localparam int unsigned RAW_W = 16;
  localparam logic [4:0] AVG_MAX = 5'h10;
  localparam logic [CNT_W-1:0] TOUCH_DELTA = 16'h0040;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  typedef enum logic [2:0]
  {
    ST_BOOT = 3'b000,
    ST_IDLE = 3'b001,
    ST_SERVE = 3'b010,
    ST_FLASH = 3'b011,
    ST_FAIL = 3'b100
  } tchq_state_t;
endpackage : tchq_pkg

// *** tchq_avg.sv ***
// Averaging filter over the last 2, 4, 8 or 16 accepted samples.
// Assumes samples arrive as one-cycle strobes from the sensing front end.
`timescale 1ns/10ps
module tchq_avg
  import tchq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] depth_sel,
  input wire logic smp_vld,
  input wire logic [RAW_W-1:0] smp_raw,
  output logic avg_vld,
  output logic [RAW_W-1:0] avg_out
);
  logic [RAW_W-1:0] hist_q [15];
  logic [ACC_W-1:0] sum_d;
  logic [4:0] depth;
  logic [2:0] shift;

  assign depth = 5'h02 << depth_sel;
  // Three bits, so the deepest setting does not wrap the shift to zero.
  assign shift = {1'b0, depth_sel} + 3'h1;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      hist_q[0] <= 16'h0000;
    else if (smp_vld)
      hist_q[0] <= smp_raw;
  end

  genvar g;
  generate
    for (g = 1; g < 15; g++)
    begin : g_shift
      always_ff @(posedge ref_clk)
      begin
        if (rst)
          hist_q[g] <= 16'h0000;
        else if (smp_vld)
          hist_q[g] <= hist_q[g-1];
      end
    end
  endgenerate

  always_comb
  begin
    // The new sample joins the sum directly, so the mean that leaves with
    // the strobe already includes it.
    sum_d = ACC_W'(smp_raw);
    for (int i = 1; i < 16; i++)
    begin
      if (5'(i) < depth)
        sum_d = sum_d + ACC_W'(hist_q[i-1]);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      avg_vld <= 1'b0;
      avg_out <= 16'h0000;
    end
    else
    begin
      avg_vld <= smp_vld;
      if (smp_vld)
        avg_out <= RAW_W'(sum_d >> shift);
    end
  end
endmodule : tchq_avg

// *** tchq_host_model.sv ***
// Host-side model: issues one access and waits until served.
// Assumes the request handshake of the touch host-port core.
`timescale 1ns/10ps
module tchq_host_model
  import tchq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic boot_done,
  input wire logic busy,
  input wire logic req_ack,
  output logic req_vld,
  output logic [1:0] req_cmd,
  output int lat
);
  initial
  begin
    req_vld = 1'b0;
    req_cmd = CMD_OTHER;
  end
  task automatic access(input logic [1:0] cmd);
    wait (boot_done === 1'b1);
    do
    begin
      @(posedge ref_clk);
      #1;
    end while (busy !== 1'b0);
    req_vld = 1'b1;
    req_cmd = cmd;
    lat = 0;
    do
    begin
      @(posedge ref_clk);
      if (req_ack !== 1'b1)
        lat++;
    end while (req_ack !== 1'b1 && lat < 50);
    #1;
    req_vld = 1'b0;
    // A released select line must not keep looking valid.
    req_cmd = ~cmd;
    while (busy !== 1'b0)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask : access
endmodule : tchq_host_model

// *** tchq_core_assertions.sv ***
// Checker on the ports of the touch host-port core.
// Assumes the flash time is longer than eight cycles.
`timescale 1ns/10ps
module tchq_core_assertions
  import tchq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_vld,
  input wire logic [1:0] req_cmd,
  input wire logic [1:0] sleep_sel,
  input wire logic bus_activity,
  input wire logic avg_en,
  input wire logic drop_en,
  input wire logic scan_start,
  input wire logic scan_done,
  input wire logic busy,
  input wire logic req_ack,
  input wire logic store_fail,
  input wire logic store_ok,
  input wire logic smp_drop,
  input wire logic smp_vld,
  input wire logic touch,
  input wire logic [RAW_W-1:0] baseline
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic act_q;
  logic take;
  logic seen_q;
  logic frz_q;
  assign take = req_vld && !busy;
  always_ff @(posedge ref_clk)
  begin
    act_q <= rst ? 1'b0 : (scan_start ? bus_activity : act_q | bus_activity);
  end
  // A touch on the first sample after reset with averaging on is latched.
  always_ff @(posedge ref_clk)
  begin
    seen_q <= rst ? 1'b0 : (seen_q | smp_vld);
    frz_q <= rst ? 1'b0 : (frz_q | (smp_vld && !seen_q && touch && avg_en));
  end
  property p_crit_ack;
    take && req_cmd == CMD_CRIT |-> ##5 req_ack;
  endproperty
  a_crit_ack: assert property (p_crit_ack)
    else $error("critical access not acknowledged in time");
  property p_store_hold;
    take && req_cmd == CMD_STORE && sleep_sel[1] |-> ##5 req_ack ##1 busy[*8];
  endproperty
  a_store_hold: assert property (p_store_hold)
    else $error("store not acknowledged or not held busy");
  property p_store_fail;
    take && req_cmd == CMD_STORE && !sleep_sel[1] |-> ##6 store_fail && !store_ok;
  endproperty
  a_store_fail: assert property (p_store_fail)
    else $error("store at fast sleep rate not refused");
  property p_drop;
    drop_en && scan_done && (act_q || bus_activity) |-> ##1 smp_drop ##1 !smp_vld;
  endproperty
  a_drop: assert property (p_drop)
    else $error("disturbed sample not discarded");
  property p_keep;
    drop_en && scan_done && !act_q && !bus_activity |-> ##2 smp_vld;
  endproperty
  a_keep: assert property (p_keep)
    else $error("quiet sample lost");
  property p_freeze;
    frz_q |-> touch && $stable(baseline);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("latched touch or baseline moved");
  c_ok: cover property (store_ok);
  c_fail: cover property (store_fail);
  c_drop: cover property (smp_drop);
  c_frz: cover property (frz_q);
endmodule : tchq_core_assertions

bind tchq_core tchq_core_assertions u_chk (.*);

// *** tchq_core_tb_top.sv ***
// Self-checking bench for the touch host-port core.
// Assumes short boot and flash parameters for run time.
`timescale 1ns/10ps
module tchq_core_tb_top
  import tchq_pkg::*;
;
  typedef struct {logic [1:0] cmd; logic [1:0] slp; int f; int o;} tchq_row_t;
  logic ref_clk, rst, req_vld, bus_activity, avg_en, drop_en;
  logic scan_start, scan_done, boot_done, req_ack, busy, store_fail;
  logic store_ok, smp_drop, smp_vld, touch;
  logic [1:0] req_cmd, sleep_sel, avg_depth;
  logic [RAW_W-1:0] scan_raw, smp_out, baseline, last_out, b;
  int lat, mismatches, num_checks, n_fail, n_ok, n_vld, n_drop, nf, no, nv;
  tchq_row_t rows [6] = '{'{CMD_CRIT, SLEEP_512HZ, 0, 0},
    '{CMD_OTHER, SLEEP_64HZ, 0, 0}, '{CMD_STORE, SLEEP_8HZ, 0, 1},
    '{CMD_STORE, SLEEP_1HZ, 0, 1}, '{CMD_STORE, SLEEP_512HZ, 1, 0},
    '{CMD_STORE, SLEEP_64HZ, 1, 0}};
  tchq_core #(.BOOT_CYC(10), .FLASH_CYC(20)) DUT (.*);
  tchq_host_model m (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    n_fail += int'(store_fail === 1'b1);
    n_ok += int'(store_ok === 1'b1);
    n_drop += int'(smp_drop === 1'b1);
    if (smp_vld === 1'b1)
    begin
      n_vld++;
      last_out = smp_out;
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    mismatches += int'(got !== exp);
  endtask : check
  task automatic do_reset;
    rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    check(16'({busy, boot_done}), 16'h0002);
    wait (boot_done === 1'b1);
    @(posedge ref_clk);
    #1;
  endtask : do_reset
  task automatic scan(input logic [15:0] raw, input logic act);
    scan_start = 1'b1;
    @(posedge ref_clk);
    #1;
    scan_start = 1'b0;
    bus_activity = act;
    @(posedge ref_clk);
    #1;
    bus_activity = 1'b0;
    scan_done = 1'b1;
    scan_raw = raw;
    @(posedge ref_clk);
    #1;
    scan_done = 1'b0;
    scan_raw = ~raw;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : scan
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial
  begin
    {bus_activity, avg_en, drop_en, scan_start, scan_done} = 5'h00;
    {sleep_sel, avg_depth, scan_raw} = 20'h00000;
    do_reset();
    foreach (rows[i])
    begin
      nf = n_fail;
      no = n_ok;
      sleep_sel = rows[i].slp;
      m.access(rows[i].cmd);
      repeat (2) @(posedge ref_clk);
      #1;
      check(16'(lat), 16'h0005);
      check(16'(n_fail - nf), 16'(rows[i].f));
      check(16'(n_ok - no), 16'(rows[i].o));
    end
    sleep_sel = SLEEP_64HZ;
    $display("access rows done");
    drop_en = 1'b1;
    nv = n_vld;
    nf = n_drop;
    scan(16'h0030, 1'b1);
    check(16'(n_drop - nf), 16'h0001);
    check(16'(n_vld - nv), 16'h0000);
    scan(16'h0031, 1'b0);
    check(last_out, 16'h0031);
    $display("drop test done");
    avg_en = 1'b1;
    // Each depth starts from cleared history, so one sample gives raw/depth.
    for (int s = 0; s < 4; s++)
    begin
      avg_depth = 2'(s);
      do_reset();
      scan(16'h0020, 1'b0);
      check(last_out, 16'h0020 >> (s + 1));
    end
    scan(16'h0030, 1'b0);
    check(last_out, 16'h0005);
    avg_depth = 2'h0;
    do_reset();
    scan(16'h1000, 1'b0);
    b = baseline;
    check(b, 16'h0800);
    scan(16'h0000, 1'b0);
    scan(16'h0000, 1'b0);
    check(16'(touch), 16'h0001);
    check(baseline, b);
    $display("filter tests done");
    wrap_up();
  end
  initial
  begin
    #20000;
    mismatches++;
    wrap_up();
  end
endmodule : tchq_core_tb_top
